// ---- flx_pkg.sv ----
// shared constants, types and timing for the flash host controller
package flx_pkg;

   // ========
   // timing
   localparam int CLK_MHZ = 200;
   localparam int T_AS_NS = 10;
   localparam int T_WP_NS = 50;
   localparam int T_WH_NS = 30;
   localparam int T_ACC_NS = 120;
   localparam int T_GAP_US = 30;
   localparam int T_CLOSE_US = 100;

   // least times round up, never below one cycle
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ns2cyc

   localparam int C_AS = ns2cyc(T_AS_NS);
   localparam int C_WP = ns2cyc(T_WP_NS);
   localparam int C_WH = ns2cyc(T_WH_NS);
   localparam int C_ACC = ns2cyc(T_ACC_NS);
   localparam int C_GAP = T_GAP_US * CLK_MHZ;
   localparam int C_CLOSE = T_CLOSE_US * CLK_MHZ;

   // ========
   // device command set
   localparam logic [14:0] ADDR_UNLOCK_A = 15'h5555;
   localparam logic [14:0] ADDR_UNLOCK_B = 15'h2AAA;
   localparam logic [7:0] CODE_UNLOCK_A = 8'hAA;
   localparam logic [7:0] CODE_UNLOCK_B = 8'h55;
   localparam logic [7:0] CODE_READ_RESET = 8'hF0;
   localparam logic [7:0] CODE_PROGRAM = 8'hA0;
   localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CODE_SUSPEND = 8'hB0;
   localparam logic [7:0] CODE_RESUME = 8'hD0;
   localparam logic [7:0] CODE_READ_STATUS = 8'h70;

   // ========
   // host register map
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_CFG = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam int CFG_BYTE_BIT = 0;
   localparam int CFG_PWD_BIT = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_LOADING_BIT = 1;
   localparam int ST_REFUSED_BIT = 2;
   localparam int ST_LATE_BIT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ========
   // types
   typedef enum logic [3:0] {
      OP_READ_RESET, OP_PROGRAM, OP_LOAD, OP_CHIP_ERASE,
      OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_READ_STATUS, OP_READ
   } flx_op_e;

   typedef struct packed {
      logic rd;
      logic last;
      logic [18:0] addr;
      logic lsb;
      logic [15:0] data;
   } flx_step_s;

endpackage : flx_pkg

// ---- flx_cyc_if.sv ----
// one flash bus cycle: request from sequencer, answer from pin engine
`timescale 1ns/1ps
interface flx_cyc_if;
   logic req;
   logic rd;
   logic byte_mode;
   logic [18:0] addr;
   logic lsb;
   logic [15:0] data;
   logic done;
   logic [15:0] rdata;

   modport ctl (output req, rd, byte_mode, addr, lsb, data,
                input done, rdata);
   modport eng (input req, rd, byte_mode, addr, lsb, data,
                output done, rdata);
endinterface : flx_cyc_if

// ---- flx_cycle.sv ----
// pin engine: one strobed write or read cycle on the flash pins
`timescale 1ns/1ps
module flx_cycle
   import flx_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   flx_cyc_if.eng cyc,
   output logic [18:0] flash_addr,
   input wire logic [15:0] flash_dq_i,
   output logic [15:0] flash_dq_o,
   output logic [15:0] flash_dq_oe,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic flash_byte_n
);

   typedef enum {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_READ, C_GAP} flx_cst_e;

   flx_cst_e st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [18:0] addr_r, addr_nxt;
   logic [15:0] dqo_r, dqo_nxt, dqoe_r, dqoe_nxt, rdata_r, rdata_nxt;
   logic ce_r, ce_nxt, we_r, we_nxt, oe_r, oe_nxt, byte_r, byte_nxt;
   logic done_r, done_nxt;
   logic [15:0] dq_s1_r, dq_s2_r;

   // ========
   // next values
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = (cnt_r != 8'h00) ? 8'(cnt_r - 8'h01) : cnt_r;
      addr_nxt = addr_r;
      dqo_nxt = dqo_r;
      dqoe_nxt = dqoe_r;
      rdata_nxt = rdata_r;
      ce_nxt = ce_r;
      we_nxt = we_r;
      oe_nxt = oe_r;
      byte_nxt = byte_r;
      done_nxt = 1'b0;
      case (st_r)
         C_IDLE:
         begin
            if (cyc.req)
            begin
               addr_nxt = cyc.addr;
               byte_nxt = cyc.byte_mode;
               ce_nxt = 1'b0;
               // byte mode: dq15 carries the lowest address bit
               dqo_nxt = cyc.byte_mode ? {cyc.lsb, 7'h00, cyc.data[7:0]}
                                       : cyc.data;
               if (cyc.rd)
               begin
                  oe_nxt = 1'b0;
                  dqoe_nxt = cyc.byte_mode ? 16'h8000 : 16'h0000;
                  cnt_nxt = 8'(C_ACC + 2);
                  st_nxt = C_READ;
               end
               else
               begin
                  dqoe_nxt = cyc.byte_mode ? 16'h80FF : 16'hFFFF;
                  cnt_nxt = 8'(C_AS - 1);
                  st_nxt = C_SETUP;
               end
            end
         end
         C_SETUP:
            if (cnt_r == 8'h00)
            begin
               we_nxt = 1'b0; // address taken at this later fall
               cnt_nxt = 8'(C_WP - 1);
               st_nxt = C_PULSE;
            end
         C_PULSE:
            if (cnt_r == 8'h00)
            begin
               we_nxt = 1'b1; // data taken at this first rise
               cnt_nxt = 8'(C_WH - 1);
               st_nxt = C_HOLD;
            end
         C_HOLD:
            if (cnt_r == 8'h00)
            begin
               ce_nxt = 1'b1;
               dqoe_nxt = 16'h0000;
               cnt_nxt = 8'(C_WH - 1);
               st_nxt = C_GAP;
            end
         C_READ:
            if (cnt_r == 8'h00)
            begin
               rdata_nxt = byte_r ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
               // strobes rise so the next read latches anew
               oe_nxt = 1'b1;
               ce_nxt = 1'b1;
               dqoe_nxt = 16'h0000;
               cnt_nxt = 8'(C_WH - 1);
               st_nxt = C_GAP;
            end
         C_GAP:
            if (cnt_r == 8'h00)
            begin
               done_nxt = 1'b1;
               st_nxt = C_IDLE;
            end
         default:
            st_nxt = C_IDLE;
      endcase
   end

   // ========
   // registers
   always_ff @(posedge clock)
   begin
      dq_s1_r <= flash_dq_i;
      dq_s2_r <= dq_s1_r;
      if (rst)
      begin
         st_r <= C_IDLE;
         cnt_r <= 8'h00;
         addr_r <= 19'h00000;
         dqo_r <= 16'h0000;
         dqoe_r <= 16'h0000;
         rdata_r <= 16'h0000;
         ce_r <= 1'b1;
         we_r <= 1'b1;
         oe_r <= 1'b1;
         byte_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         addr_r <= addr_nxt;
         dqo_r <= dqo_nxt;
         dqoe_r <= dqoe_nxt;
         rdata_r <= rdata_nxt;
         ce_r <= ce_nxt;
         we_r <= we_nxt;
         oe_r <= oe_nxt;
         byte_r <= byte_nxt;
         done_r <= done_nxt;
      end
   end

   assign cyc.done = done_r;
   assign cyc.rdata = rdata_r;
   assign flash_addr = addr_r;
   assign flash_dq_o = dqo_r;
   assign flash_dq_oe = dqoe_r;
   assign flash_ce_n = ce_r;
   assign flash_we_n = we_r;
   assign flash_oe_n = oe_r;
   assign flash_byte_n = ~byte_r;

endmodule : flx_cycle

// ---- flx_host.sv ----
// flash host controller: axi4-lite registers, command sequencer, pins
// What this block does
// - address at later fall, data at first rise
// - page is A6..A18, held every load
// - next load fall within 30us
// - chip erase is six writes, code 10
// - sector erase six writes, code 30
// - status frozen at fall; toggle per read
// - unlocks AA@5555, 55@2AAA, A0..A14 only
`timescale 1ns/1ps
module flx_host
   import flx_pkg::*;
#(
   parameter int LOAD_GAP_CYC = C_GAP,
   parameter int LOAD_CLOSE_CYC = C_CLOSE
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [18:0] flash_addr,
   input wire logic [15:0] flash_dq_i,
   output logic [15:0] flash_dq_o,
   output logic [15:0] flash_dq_oe,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic flash_byte_n,
   output logic deep_powerdown_n
);

   // time from launch to load fall plus from load rise to done
   localparam int LOAD_LEAD = C_AS + 2 * C_WH + 2;

   typedef enum {H_IDLE, H_ISSUE, H_WAIT} flx_hst_e;

   // ========
   // helpers
   function automatic logic [31:0] merge32(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (nw & m);
   endfunction : merge32

   function automatic flx_step_s seq_step(input flx_op_e op,
      input logic [2:0] idx, input logic [19:0] a, input logic [15:0] d);
      flx_step_s s;
      logic erase;
      erase = (op == OP_CHIP_ERASE) || (op == OP_SECTOR_ERASE);
      s = '0;
      // unlock pair, upper address bits driven zero
      s.addr = {4'h0, (idx == 3'h1 || idx == 3'h4) ? ADDR_UNLOCK_B
                                                   : ADDR_UNLOCK_A};
      s.data = {8'h00, (idx == 3'h1 || idx == 3'h4) ? CODE_UNLOCK_B
                                                    : CODE_UNLOCK_A};
      if (op == OP_LOAD || op == OP_READ)
      begin
         s.rd = (op == OP_READ);
         s.addr = a[19:1];
         s.lsb = a[0];
         s.data = d;
         s.last = 1'b1;
      end
      else if (idx == 3'h2)
      begin
         s.last = !erase; // three-write prefix ends here
         case (op)
            OP_PROGRAM: s.data = {8'h00, CODE_PROGRAM};
            OP_SUSPEND: s.data = {8'h00, CODE_SUSPEND};
            OP_RESUME: s.data = {8'h00, CODE_RESUME};
            OP_READ_STATUS: s.data = {8'h00, CODE_READ_STATUS};
            OP_READ_RESET: s.data = {8'h00, CODE_READ_RESET};
            default: s.data = {8'h00, CODE_ERASE_SETUP};
         endcase
      end
      else if (idx == 3'h5)
      begin
         s.last = 1'b1;
         if (op == OP_SECTOR_ERASE)
         begin
            s.addr = a[19:1]; // A18..A16 name the sector
            s.data = {8'h00, CODE_SECTOR_ERASE};
         end
         else
            s.data = {8'h00, CODE_CHIP_ERASE};
      end
      return s;
   endfunction : seq_step

   // ========
   // state
   flx_cyc_if cyc ();

   flx_hst_e st_r, st_nxt;
   flx_op_e op_r, op_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] ardata_r, ardata_nxt;
   logic [19:0] addr_r, addr_nxt;
   logic [15:0] wreg_r, wreg_nxt, rreg_r, rreg_nxt;
   logic [1:0] cfg_r, cfg_nxt;
   logic refused_r, refused_nxt, late_r, late_nxt;
   logic loading_r, loading_nxt, loaded_r, loaded_nxt, bytem_r, bytem_nxt;
   logic [12:0] page_r, page_nxt;
   logic [15:0] gap_r, gap_nxt;
   logic [7:0] wa;
   logic [31:0] wd, w32, st32;
   logic [3:0] ws;
   logic wr_go;
   flx_op_e wop;
   flx_step_s step;

   assign step = seq_step(op_r, idx_r, addr_r, wreg_r);
   assign st32 = {28'h0000000, late_r, refused_r, loading_r,
                  st_r != H_IDLE};

   // ========
   // next values
   always_comb
   begin
      st_nxt = st_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r && !s_axi_bready;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r && !s_axi_rready;
      rresp_nxt = rresp_r;
      ardata_nxt = ardata_r;
      addr_nxt = addr_r;
      wreg_nxt = wreg_r;
      rreg_nxt = rreg_r;
      cfg_nxt = cfg_r;
      refused_nxt = refused_r;
      late_nxt = late_r;
      loading_nxt = loading_r;
      loaded_nxt = loaded_r;
      bytem_nxt = bytem_r;
      page_nxt = page_r;
      gap_nxt = (gap_r != 16'hFFFF) ? 16'(gap_r + 16'h0001) : gap_r;
      // load period closes by itself once the device timer expires
      if (loading_r && int'(gap_r) >= LOAD_CLOSE_CYC - 1)
         loading_nxt = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      wa = aw_held_r ? awaddr_r : s_axi_awaddr;
      wd = w_held_r ? wdata_r : s_axi_wdata;
      ws = w_held_r ? wstrb_r : s_axi_wstrb;
      wop = flx_op_e'(wd[3:0]);
      w32 = 32'h00000000;
      wr_go = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
              (w_held_r || (s_axi_wvalid && s_axi_wready));
      // sequencer
      case (st_r)
         H_ISSUE:
            st_nxt = H_WAIT;
         H_WAIT:
            if (cyc.done)
            begin
               if (step.rd)
                  rreg_nxt = cyc.rdata;
               if (step.last)
               begin
                  st_nxt = H_IDLE;
                  if (op_r == OP_PROGRAM)
                  begin
                     loading_nxt = 1'b1;
                     loaded_nxt = 1'b0;
                     gap_nxt = 16'h0000;
                  end
                  if (op_r == OP_LOAD)
                  begin
                     loaded_nxt = 1'b1;
                     page_nxt = addr_r[19:7];
                     gap_nxt = 16'h0000; // timed from the load's done, after its hold and gap
                  end
               end
               else
               begin
                  idx_nxt = 3'(idx_r + 3'h1);
                  st_nxt = H_ISSUE;
               end
            end
         default:
            st_nxt = H_IDLE;
      endcase
      // register writes; a clear here wins over a hardware set above
      if (wr_go)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         case ({wa[7:2], 2'b00})
            REG_ADDR:
            begin
               w32 = merge32({12'h000, addr_r}, wd, ws);
               addr_nxt = w32[19:0];
            end
            REG_WDATA:
            begin
               w32 = merge32({16'h0000, wreg_r}, wd, ws);
               wreg_nxt = w32[15:0];
            end
            REG_CFG:
            begin
               w32 = merge32({30'h00000000, cfg_r}, wd, ws);
               cfg_nxt = w32[1:0];
            end
            REG_STATUS:
            begin
               w32 = merge32(32'h00000000, wd, ws);
               if (w32[ST_REFUSED_BIT])
                  refused_nxt = 1'b0;
               if (w32[ST_LATE_BIT])
                  late_nxt = 1'b0;
            end
            REG_RDATA: ;
            REG_CMD:
               if (ws[0])
               begin
                  if (st_r != H_IDLE || cfg_r[CFG_PWD_BIT] ||
                      wd[3:0] > 4'(OP_READ))
                     refused_nxt = 1'b1; // no commands in power-down
                  else if (wop == OP_LOAD &&
                           (!loading_r ||
                            int'(gap_r) + LOAD_LEAD >= LOAD_GAP_CYC))
                  begin
                     refused_nxt = 1'b1; // too late for the window
                     late_nxt = 1'b1;
                  end
                  else if (wop == OP_LOAD && loaded_r &&
                           addr_r[19:7] != page_r)
                     refused_nxt = 1'b1; // page must stay fixed
                  else
                  begin
                     op_nxt = wop;
                     idx_nxt = 3'h0;
                     st_nxt = H_ISSUE;
                     if (wop != OP_LOAD)
                     begin
                        loading_nxt = 1'b0;
                        // width held for the whole operation
                        bytem_nxt = cfg_r[CFG_BYTE_BIT];
                     end
                  end
               end
            default:
               bresp_nxt = RESP_SLVERR;
         endcase
      end
      // register reads
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            REG_CMD: ardata_nxt = {28'h0000000, op_r};
            REG_ADDR: ardata_nxt = {12'h000, addr_r};
            REG_WDATA: ardata_nxt = {16'h0000, wreg_r};
            REG_RDATA: ardata_nxt = {16'h0000, rreg_r};
            REG_CFG: ardata_nxt = {30'h00000000, cfg_r};
            REG_STATUS: ardata_nxt = st32;
            default:
            begin
               ardata_nxt = 32'h00000000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
   end

   // ========
   // registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_r <= H_IDLE;
         op_r <= OP_READ_RESET;
         idx_r <= 3'h0;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         ardata_r <= 32'h00000000;
         addr_r <= 20'h00000;
         wreg_r <= 16'h0000;
         rreg_r <= 16'h0000;
         cfg_r <= CFG_RESET;
         refused_r <= 1'b0;
         late_r <= 1'b0;
         loading_r <= 1'b0;
         loaded_r <= 1'b0;
         bytem_r <= 1'b0;
         page_r <= 13'h0000;
         gap_r <= 16'h0000;
      end
      else
      begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         ardata_r <= ardata_nxt;
         addr_r <= addr_nxt;
         wreg_r <= wreg_nxt;
         rreg_r <= rreg_nxt;
         cfg_r <= cfg_nxt;
         refused_r <= refused_nxt;
         late_r <= late_nxt;
         loading_r <= loading_nxt;
         loaded_r <= loaded_nxt;
         bytem_r <= bytem_nxt;
         page_r <= page_nxt;
         gap_r <= gap_nxt;
      end
   end

   // ========
   // outputs and pin engine
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = ardata_r;
   assign deep_powerdown_n = ~cfg_r[CFG_PWD_BIT];

   assign cyc.req = (st_r == H_ISSUE);
   assign cyc.rd = step.rd;
   assign cyc.byte_mode = bytem_r;
   assign cyc.addr = step.addr;
   assign cyc.lsb = step.lsb;
   assign cyc.data = step.data;

   flx_cycle i_flx_cycle (
      .clock(clock),
      .rst(rst),
      .cyc(cyc),
      .flash_addr(flash_addr),
      .flash_dq_i(flash_dq_i),
      .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe),
      .flash_ce_n(flash_ce_n),
      .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n),
      .flash_byte_n(flash_byte_n)
   );

endmodule : flx_host

// ---- flx_host_properties.sv ----
// port assertions for the flash host controller
`timescale 1ns/1ps
module flx_host_properties (
   input wire logic clock,
   input wire logic rst,
   input wire logic [18:0] flash_addr,
   input wire logic [15:0] flash_dq_o,
   input wire logic [15:0] flash_dq_oe,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n
);
   // ========
   // flash strobe timing
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_we; !flash_we_n |-> flash_oe_n && !flash_ce_n; endproperty
   a_we: assert property (p_we) else $error("we alone");
   property p_su; $fell(flash_we_n) |-> $past(!flash_ce_n, 2); endproperty
   a_su: assert property (p_su) else $error("setup");
   property p_wp; $fell(flash_we_n) |-> !flash_we_n [*8]; endproperty
   a_wp: assert property (p_wp) else $error("pulse");
   property p_ho; $rose(flash_ce_n) |-> $past(flash_we_n, 6); endproperty
   a_ho: assert property (p_ho) else $error("hold");
   property p_pa;
      !flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr);
   endproperty
   a_pa: assert property (p_pa) else $error("addr moved");
   property p_wd;
      !flash_we_n |-> &flash_dq_oe[7:0] && $stable(flash_dq_o);
   endproperty
   a_wd: assert property (p_wd) else $error("data");
   property p_rd;
      !flash_oe_n |-> flash_dq_oe[14:0] == 15'h0000 && flash_we_n;
   endproperty
   a_rd: assert property (p_rd) else $error("read drive");
   property p_tg; $rose(flash_oe_n) |-> flash_ce_n; endproperty
   a_tg: assert property (p_tg) else $error("toggle");
endmodule : flx_host_properties
bind flx_host flx_host_properties i_flx_host_properties (.clock, .rst,
   .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_we_n,
   .flash_oe_n);

// ---- flx_flash_model.sv ----
// behavioural flash device behind the host pins, word mode
`timescale 1ns/1ps
module flx_flash_model #(
   parameter int ERASE_NS = 10000,
   parameter int CLOSE_NS = 2000
)
(
   input wire logic [18:0] a,
   input wire logic [15:0] d,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic pwd_n,
   output logic [15:0] q = 16'h5AA5
);
   // ========
   // command decode and timed operations
   logic [15:0] mem [int];
   logic [15:0] pg [int];
   logic [7:0] st = 8'h80;
   logic [18:0] la;
   logic [7:0] c;
   logic [2:0] ea;
   int n = 0;
   int tl = 0;
   int te = 0;
   bit rs = 0, ld = 0, er = 0, ch = 0;
   always @(negedge we_n) if (!ce_n) la = a;
   always @(posedge we_n)
      if (!ce_n && pwd_n)
      begin
         c = d[7:0];
         if (ld)
         begin
            pg[la] = d;
            tl = 0;
         end
         else if (n % 3 == 0 && la[14:0] == 15'h5555 && c == 8'hAA)
            n++;
         else if (n % 3 == 1 && la[14:0] == 15'h2AAA && c == 8'h55)
            n++;
         else if (n == 2 && c == 8'h80 && st[7] && !st[6])
            n = 3;
         else if (n == 5 && (c == 8'h10 || c == 8'h30))
         begin
            {er, rs, ch, st[7], n, te} = {2'b11, !c[5], 1'b0, 64'h0};
            ea = la[18:16];
         end
         else if (n == 2)
         begin
            n = 0;
            case (c)
               8'h70: rs = 1;
               8'hF0: if (st[7]) {rs, st[2]} = 2'b00;
               8'hA0: if (st[7] && !st[6]) {ld, rs, st[7]} = 3'b110;
               8'hB0: if (er) st[7:6] = 2'b11;
               8'hD0: if (st[6]) st[7:6] = 2'b00;
               default: ;
            endcase
            if (ld) pg.delete();
            tl = 0;
         end
         else
            n = 0;
      end
   always #100
   begin
      tl = tl + 100;
      if (er && !st[6]) te = te + 100;
      if (ld && tl > CLOSE_NS) {ld, st[7]} = 2'b01;
      if (!ld) foreach (pg[i]) mem[i] = pg[i];
      if (!ld) pg.delete();
      if (er && te > ERASE_NS) {er, st[7]} = 2'b01;
      if (!er && te > 0) foreach (mem[i]) if (ch || i[18:16] == ea)
         mem[i] = 16'hFFFF;
      if (!er) te = 0;
   end
   always @(negedge oe_n or negedge ce_n)
      if (!ce_n && !oe_n && pwd_n)
         q = rs ? {8'h00, st[7:2], 2'b00} : mem.exists(a) ? mem[a]
            : 16'hFFFF;
   always @(posedge oe_n) q = ~q;
   always @(negedge pwd_n) {st, ld, er, rs, n} = {8'h80, 35'h0};
endmodule : flx_flash_model

// ---- test_flx_host.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module test_flx_host;
   import flx_pkg::*;
   logic clock = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic [7:0] aa = 8'h00;
   logic [31:0] wd = 32'h0, x, rdt, pg;
   logic awr, wr, bv, arr, rv, ce, we, oe, pd;
   logic [1:0] br;
   logic [18:0] fa;
   logic [15:0] fi, fo;
   logic [15:0] v [3];
   int n_errors = 0, check_count = 0, k, r, j, i;
   int o [3] = '{63, 0, 1};
   initial forever #2.5 clock = ~clock;
   flx_host #(.LOAD_GAP_CYC(200), .LOAD_CLOSE_CYC(400)) i_flx_host (
      .clock(clock), .rst(rst), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(aa),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
      .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .flash_addr(fa), .flash_dq_i(fi), .flash_dq_o(fo), .flash_dq_oe(),
      .flash_ce_n(ce), .flash_we_n(we), .flash_oe_n(oe), .flash_byte_n(),
      .deep_powerdown_n(pd));
   flx_flash_model i_flx_flash_model (.a(fa), .d(fo), .ce_n(ce),
      .we_n(we), .oe_n(oe), .pwd_n(pd), .q(fi));
   // ========
   // bus tasks and checks
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] s, e);
      check_count++;
      if (s !== e)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      {aa, wd, awv, wv, bre, arv, rre} <= {a, d, w, w, w, !w, !w};
      k = 0;
      do
      begin
         @(posedge clock);
         if (awv && awr) awv <= 0;
         if (wv && wr) wv <= 0;
         if (arv && arr) arv <= 0;
         if (bre && bv) {x, bre} <= {30'h0, br, 1'b0};
         if (rre && rv) {x, rre} <= {rdt, 1'b0};
      end while ((awv | wv | arv | bre | rre) && ++k < 99);
      if (k >= 99) n_errors++;
      if (k >= 99) stop_test();
   endtask : bus
   task automatic op(input logic [3:0] c);
      bus(1, REG_CMD, {28'h0, c});
      r = 0;
      do bus(0, REG_STATUS, 0); while (x[ST_BUSY_BIT] !== 1'b0 && ++r < 99);
   endtask : op
   task automatic dr(input logic [31:0] a);
      bus(1, REG_ADDR, a);
      op(8);
      bus(0, REG_RDATA, 0);
   endtask : dr
   task automatic poll();
      j = 0;
      do dr(pg); while (x[7] !== 1'b1 && ++j < 200);
   endtask : poll
   function automatic logic [31:0] st(input logic rdy, sus);
      return {24'h0, rdy, sus, 6'h00};
   endfunction : st
   // ========
   // scenarios
   initial
   begin
      r = $urandom(32'h0223872E);
      repeat (3) @(posedge clock);
      rst <= 0;
      bus(0, REG_CFG, 0);
      chk("cfg", x, 0);
      bus(1, 8'h20, 1);
      chk("bresp", x, 2);
      op(7);
      dr($urandom & 32'hFFFFE);
      chk("status", x, st(1, 0));
      pg = $urandom & 32'hFFF80;
      o[2] = 1 + $urandom % 31;
      op(1);
      for (i = 0; i < 3; i++)
      begin
         v[i] = $urandom;
         bus(1, REG_ADDR, pg + o[i] * 2);
         bus(1, REG_WDATA, {16'h0, v[i]});
         op(2);
      end
      poll();
      chk("prog", x, st(1, 0));
      op(0);
      for (i = 0; i < 3; i++)
      begin
         dr(pg + o[i] * 2);
         chk("data", x, {16'h0, v[i]});
      end
      dr(pg + o[2] * 2 + 2);
      chk("blank", x, 32'hFFFF);
      op(4);
      op(5);
      dr(pg);
      chk("susp", x, st(1, 1));
      op(6);
      dr(pg);
      chk("resume", x, st(0, 0));
      op(0);
      dr(pg);
      chk("ignored", x, st(0, 0));
      poll();
      chk("erase", x, st(1, 0));
      op(0);
      dr(pg);
      chk("erased", x, 32'hFFFF);
      op(3);
      bus(1, REG_CFG, 2);
      chk("pwd", {31'h0, pd}, 0);
      bus(1, REG_CFG, 0);
      op(7);
      dr(pg);
      chk("wake", x, st(1, 0));
      stop_test();
   end
endmodule : test_flx_host
